//--- verilog/udt_timer.sv
/*
 * 8-bit up/down timer with interval and auto-reload modes,
 * wishbone classic register slave, synchronised pin inputs.
 * assumes one 20 MHz clock, synchronous reset, and an outside
 * interrupt controller that latches the wrap pulse.
 */
// Contract
// RULE_01: 8-bit counter steps by one per input clock, interval or auto-reload mode.
// RULE_02: clock from six system prescales, subclock divided by four, or event pin.
// RULE_03: request an interrupt on overflow, or underflow when counting down.
// RULE_04: in subclock power modes only subclock or event sources keep counting.
// RULE_05: a module standby state halts the timer independently.
// RULE_06: event input pin and direction select pin are accepted.
// RULE_07: mode at ffb4; ffb5 reads counter, writes reload; both reset zero.
// RULE_08: clock stop register at fffa, read/write, resets to all ones.
// RULE_09: mode register resets to 18: interval, up, first clock source.
// RULE_10: mode bit 7 picks interval (0) or auto-reload (1).
// RULE_11: bits 6,5: 00 up, 01 down, bit 6 set gives pin control.
// RULE_12: under pin control count down while pin high, up while low.
// RULE_13: mode bits 4 and 3 read one and ignore writes.
// RULE_14: mode bits 2..0 pick clock source; event edge is selectable.
// RULE_15: up from ff wraps to 00, down from 00 to ff; sets flag.
// RULE_16: reload write loads counter; auto-reload reloads on every wrap.
// RULE_17: clock code 111 counts edges of the event pin.
// RULE_18: stop register bit 1 low puts timer in standby; high releases.
// RULE_19: codes 000..110 map to /8192,/2048,/512,/64,/16,/4, subclock/4.
// RULE_20: subclock source and event pin are synchronised before counting.
`timescale 1ns/100ps
`default_nettype none

module udt_timer
    import udt_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [17:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        event_input_pin_i,
    input  wire logic        direction_select_pin_i,
    input  wire logic        sub_clk_div4_i,
    input  wire logic        sub_mode_i,
    output logic             wrap_interrupt_flag_set_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    udt_mode_t          mode;
    logic [7:0]         count_value;
    logic [7:0]         reload_value;
    logic [7:0]         module_clock_stop;
    logic [7:0]         event_edge_ctrl;
    logic [PRE_W-1:0]   pre;
    logic [2:0]         pin_s1;
    logic [2:0]         pin_s2;
    logic [2:0]         pin_s3;
    logic [2:0]         pin_lvl;
    logic [2:0]         pin_prev;
    logic [31:0]        next_rdata;
    logic [7:0]         next_count;
    logic               src_tick;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic        req;
    logic        wr;
    logic [15:0] word;
    logic        hit_mode;
    logic        hit_count;
    logic        hit_stop;
    logic        hit_edge;
    logic        load;

    assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign word      = wb_adr_i[17:2];
    assign hit_mode  = (word == IDX_MODE);
    assign hit_count = (word == IDX_COUNT);
    assign hit_stop  = (word == IDX_STOP);
    assign hit_edge  = (word == IDX_EDGE);
    // write lands at the edge where the master sees ack high
    assign wr        = ce_i & wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign load      = wr & hit_count;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= req;
        end
    end

    always_comb begin
        next_rdata = '0;
        if (hit_mode) begin
            next_rdata[7:0] = mode; // RULE_13
        end else if (hit_count) begin
            next_rdata[7:0] = count_value; // RULE_07
        end else if (hit_stop) begin
            next_rdata[7:0] = module_clock_stop; // RULE_08
        end else if (hit_edge) begin
            next_rdata[7:0] = event_edge_ctrl;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_dat_o <= (req & ~wb_we_i) ? next_rdata : '0;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= udt_mode_t'(MODE_RESET); // RULE_09
        end else if (wr & hit_mode) begin
            mode <= udt_mode_t'({wb_dat_i[7:5], MODE_FIXED, wb_dat_i[2:0]}); // RULE_13
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            module_clock_stop <= STOP_RESET; // RULE_08
        end else if (wr & hit_stop) begin
            module_clock_stop <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_edge_ctrl <= EDGE_RESET;
        end else if (wr & hit_edge) begin
            event_edge_ctrl <= wb_dat_i[7:0]; // RULE_14
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_value <= RELOAD_RESET; // RULE_07
        end else if (load) begin
            reload_value <= wb_dat_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers: sub clock, direction, event
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1   <= '0;
            pin_s2   <= '0;
            pin_s3   <= '0;
            pin_lvl  <= '0;
            pin_prev <= '0;
        end else if (ce_i) begin
            pin_s1   <= {sub_clk_div4_i, direction_select_pin_i, event_input_pin_i}; // RULE_06
            pin_s2   <= pin_s1; // RULE_20
            pin_s3   <= pin_s2;
            pin_lvl  <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_lvl & (pin_s2 ^ pin_s3));
            pin_prev <= pin_lvl;
        end
    end

    logic evt_rise;
    logic evt_fall;
    logic sub_rise;
    logic dir_pin;

    assign evt_rise = pin_lvl[0] & ~pin_prev[0];
    assign evt_fall = ~pin_lvl[0] & pin_prev[0];
    assign dir_pin  = pin_lvl[1];
    assign sub_rise = pin_lvl[2] & ~pin_prev[2];

    // ----------------------------------------------------------------
    // prescaler and source select
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre <= '0;
        end else if (ce_i) begin
            pre <= pre + 13'h0001;
        end
    end

    always_comb begin
        case (mode.clock_source_select) // RULE_19 RULE_02
            SRC_8192: src_tick = ((pre & MASK_8192) == MASK_8192);
            SRC_2048: src_tick = ((pre & MASK_2048) == MASK_2048);
            SRC_512:  src_tick = ((pre & MASK_512) == MASK_512);
            SRC_64:   src_tick = ((pre & MASK_64) == MASK_64);
            SRC_16:   src_tick = ((pre & MASK_16) == MASK_16);
            SRC_4:    src_tick = ((pre & MASK_4) == MASK_4);
            SRC_SUB:  src_tick = sub_rise;
            SRC_EXT:  src_tick = event_edge_ctrl[EDGE_BIT] ? evt_rise : evt_fall; // RULE_17 RULE_14
            default:  src_tick = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    logic run;
    logic tick;
    logic down;
    logic wrap;
    logic slow_ok;

    assign slow_ok = (mode.clock_source_select == SRC_SUB)
                   | (mode.clock_source_select == SRC_EXT);
    assign run  = module_clock_stop[STANDBY_BIT] & (~sub_mode_i | slow_ok); // RULE_18 RULE_05 RULE_04
    assign tick = ce_i & run & src_tick;
    assign down = mode.direction_by_pin ? dir_pin : mode.direction_by_software; // RULE_11 RULE_12
    assign wrap = tick & (down ? (count_value == COUNT_MIN) : (count_value == COUNT_MAX)); // RULE_15

    always_comb begin
        next_count = count_value;
        if (load) begin
            next_count = wb_dat_i[7:0]; // RULE_16
        end else if (wrap) begin
            if (mode.reload_mode_select) begin
                next_count = reload_value; // RULE_10 RULE_16
            end else begin
                next_count = down ? COUNT_MAX : COUNT_MIN; // RULE_15
            end
        end else if (tick) begin
            next_count = down ? count_value - 8'h01 : count_value + 8'h01; // RULE_01
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_value <= COUNT_RESET; // RULE_07
        end else begin
            count_value <= next_count;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wrap_interrupt_flag_set_o <= 1'b0;
        end else if (ce_i) begin
            wrap_interrupt_flag_set_o <= wrap; // RULE_03
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
        (ce_i & req) |=> (wb_ack_o ##1 !wb_ack_o))
        else $error("ack not a single pulse after request");

    reset_value_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
        $past(rst_i) |-> (mode == MODE_RESET && count_value == COUNT_RESET
                          && module_clock_stop == STOP_RESET))
        else $error("wrong value after reset");

    fixed_bits_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
        (ce_i & req & ~wb_we_i & hit_mode) |=> (wb_dat_o[4:3] == 2'h3))
        else $error("mode bits 4 and 3 not read as one");

    up_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
        (tick & ~down & ~load & count_value == 8'hff & ~mode.reload_mode_select)
        |=> (count_value == 8'h00 && wrap_interrupt_flag_set_o))
        else $error("overflow did not wrap to zero with flag");

    down_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
        (tick & down & ~load & count_value == 8'h00 & ~mode.reload_mode_select)
        |=> (count_value == 8'hff && wrap_interrupt_flag_set_o))
        else $error("underflow did not wrap to ff with flag");

    reload_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
        (wrap & ~load & mode.reload_mode_select) |=> (count_value == $past(reload_value)))
        else $error("auto-reload did not load reload value");

    write_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
        load |=> (count_value == $past(wb_dat_i[7:0]) && reload_value == count_value))
        else $error("reload write did not load counter");

    standby_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_18
        (~module_clock_stop[1] & ~load) |=> (count_value == $past(count_value)))
        else $error("counter moved in standby");

    sub_mode_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
        (sub_mode_i & mode.clock_source_select < 3'h6 & ~load)
        |=> (count_value == $past(count_value)))
        else $error("counter moved on fast source in subclock mode");

    pin_down_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
        (tick & mode.direction_by_pin & dir_pin & ~load & count_value != 8'h00)
        |=> (count_value == $past(count_value) - 8'h01))
        else $error("pin high did not count down");

endmodule

`default_nettype wire

//--- verilog/udt_pkg.sv
/*
 * constants and types for the 8-bit up/down reload timer.
 * assumes a 32-bit classic wishbone slave port, one register per word.
 */
`default_nettype none

package udt_pkg;

    // ----------------------------------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_MODE  = 16'hffb4;
    localparam logic [15:0] IDX_COUNT = 16'hffb5;
    localparam logic [15:0] IDX_EDGE  = 16'hffb6;
    localparam logic [15:0] IDX_STOP  = 16'hfffa;

    // ----------------------------------------------------------------
    // reset values and fixed fields
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_RESET   = 8'h18;
    localparam logic [7:0] COUNT_RESET  = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] STOP_RESET   = 8'hff;
    localparam logic [7:0] EDGE_RESET   = 8'h00;
    localparam logic [1:0] MODE_FIXED   = 2'h3;
    localparam int         STANDBY_BIT  = 1;
    localparam int         EDGE_BIT     = 0;
    localparam logic [7:0] COUNT_MAX    = 8'hff;
    localparam logic [7:0] COUNT_MIN    = 8'h00;

    // ----------------------------------------------------------------
    // clock source codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SRC_8192 = 3'h0;
    localparam logic [2:0] SRC_2048 = 3'h1;
    localparam logic [2:0] SRC_512  = 3'h2;
    localparam logic [2:0] SRC_64   = 3'h3;
    localparam logic [2:0] SRC_16   = 3'h4;
    localparam logic [2:0] SRC_4    = 3'h5;
    localparam logic [2:0] SRC_SUB  = 3'h6;
    localparam logic [2:0] SRC_EXT  = 3'h7;

    // ----------------------------------------------------------------
    // prescaler divide counts as all-ones masks
    // ----------------------------------------------------------------
    localparam int          PRE_W     = 13;
    localparam logic [12:0] MASK_8192 = 13'h1fff;
    localparam logic [12:0] MASK_2048 = 13'h07ff;
    localparam logic [12:0] MASK_512  = 13'h01ff;
    localparam logic [12:0] MASK_64   = 13'h003f;
    localparam logic [12:0] MASK_16   = 13'h000f;
    localparam logic [12:0] MASK_4    = 13'h0003;

    // ----------------------------------------------------------------
    // mode register layout
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       reload_mode_select;
        logic       direction_by_pin;
        logic       direction_by_software;
        logic [1:0] fixed_ones;
        logic [2:0] clock_source_select;
    } udt_mode_t;

endpackage

`default_nettype wire

//--- testbench/tb.sv
/*
 * self-checking bench for the 8-bit up/down reload timer.
 * assumes udt_pkg and udt_timer, one 50 ns clock, ce_i held high.
 */
`timescale 1ns/100ps
`default_nettype none

module tb
    import udt_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [17:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        ev_pin;
    logic        dir_pin;
    logic        sub_clk;
    logic        sub_mode;
    logic        wrap;
    logic [7:0]  q;
    int          bad_count  = 0;
    int          num_checks = 0;
    int          wraps      = 0;
    int          w0;
    int          divs [6]   = '{8192, 2048, 512, 64, 16, 4};
    logic [7:0]  t_mode [6] = '{8'h07, 8'h27, 8'h47, 8'h47, 8'h87, 8'ha7};
    logic [7:0]  t_rel [6]  = '{8'hfe, 8'h01, 8'h06, 8'h06, 8'hfe, 8'h01};
    logic [7:0]  t_exp [6]  = '{8'h00, 8'hff, 8'h04, 8'h08, 8'hfe, 8'h01};
    logic [7:0]  t_wrap [6] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01};
    logic [5:0]  t_dir      = 6'b000100;

    udt_timer DUT (
        .clk_i                     (clk_i),
        .rst_i                     (rst_i),
        .ce_i                      (1'b1),
        .wb_cyc_i                  (cyc),
        .wb_stb_i                  (stb),
        .wb_we_i                   (we),
        .wb_adr_i                  (adr),
        .wb_sel_i                  (4'hf),
        .wb_dat_i                  (wdat),
        .wb_dat_o                  (rdat),
        .wb_ack_o                  (ack),
        .event_input_pin_i         (ev_pin),
        .direction_select_pin_i    (dir_pin),
        .sub_clk_div4_i            (sub_clk),
        .sub_mode_i                (sub_mode),
        .wrap_interrupt_flag_set_o (wrap)
    );

    // ----------------------------------------------------------------
    // clock and wrap pulse counting
    // ----------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (wrap === 1'b1) begin
            wraps <= wraps + 1;
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'h0};
        wdat <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (n >= 40) begin
            bad_count++;
            $display("ERROR t=%0t ack %h exp %h", $time, ack, 1'b1);
            end_of_test();
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(q, exp);
    endtask

    task automatic edge_pin(input logic sub, input logic v);
        @(posedge clk_i);
        if (sub) begin
            sub_clk <= v;
        end else begin
            ev_pin <= v;
        end
        repeat (8) @(posedge clk_i);
    endtask

    task automatic step(input logic v, input logic [7:0] exp);
        edge_pin(1'b0, v);
        rd(IDX_COUNT, exp);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, ev_pin, dir_pin, sub_clk, sub_mode} = 7'h00;
        adr  = 18'h00000;
        wdat = 32'h00000000;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values and fixed bits
        rd(IDX_MODE, 8'h18);
        rd(IDX_STOP, 8'hff);
        rd(IDX_EDGE, 8'h00);
        rd(16'hfff0, 8'h00);
        wr(IDX_MODE, 8'h07);
        rd(IDX_MODE, 8'h1f);
        wr(IDX_STOP, 8'h5a);
        rd(IDX_STOP, 8'h5a);
        // standby, reload load, event edges
        wr(IDX_STOP, 8'hfd);
        wr(IDX_COUNT, 8'h10);
        rd(IDX_COUNT, 8'h10);
        step(1'b1, 8'h10);
        step(1'b0, 8'h10);
        wr(IDX_STOP, 8'hff);
        step(1'b1, 8'h10);
        step(1'b0, 8'h11);
        wr(IDX_EDGE, 8'h01);
        step(1'b1, 8'h12);
        step(1'b0, 8'h12);
        // direction, wrap and reload modes
        for (int i = 0; i < 6; i++) begin
            dir_pin <= t_dir[i];
            wr(IDX_MODE, t_mode[i]);
            rd(IDX_MODE, t_mode[i] | 8'h18);
            w0 = wraps;
            wr(IDX_COUNT, t_rel[i]);
            repeat (2) begin
                edge_pin(1'b0, 1'b1);
                edge_pin(1'b0, 1'b0);
            end
            rd(IDX_COUNT, t_exp[i]);
            chk(8'(wraps - w0), t_wrap[i]);
        end
        // subclock power mode sources
        @(posedge clk_i);
        sub_mode <= 1'b1;
        wr(IDX_MODE, 8'h05);
        wr(IDX_COUNT, 8'h20);
        repeat (40) @(posedge clk_i);
        rd(IDX_COUNT, 8'h20);
        wr(IDX_MODE, 8'h07);
        step(1'b1, 8'h21);
        step(1'b0, 8'h21);
        wr(IDX_MODE, 8'h06);
        edge_pin(1'b1, 1'b1);
        edge_pin(1'b1, 1'b0);
        rd(IDX_COUNT, 8'h22);
        @(posedge clk_i);
        sub_mode <= 1'b0;
        // prescaled sources, four periods each
        for (int i = 0; i < 6; i++) begin
            wr(IDX_STOP, 8'hfd);
            wr(IDX_COUNT, 8'h00);
            wr(IDX_MODE, 8'(i));
            wr(IDX_STOP, 8'hff);
            repeat (4 * divs[i]) @(posedge clk_i);
            wr(IDX_STOP, 8'hfd);
            bus(1'b0, IDX_COUNT, 8'h00);
            num_checks++;
            if ((q inside {8'h04, 8'h05}) !== 1'b1) begin
                bad_count++;
                $display("ERROR t=%0t got %h exp %h", $time, q, 8'h04);
            end
        end
        end_of_test();
    end
endmodule

`default_nettype wire
